// file: dac_ctrl_map.vh
`ifndef DAC_CTRL_MAP_VH
`define DAC_CTRL_MAP_VH

// Register byte offsets, one aligned 32-bit word each
`define OFS_CONTROL_A     6'h00
`define OFS_CONTROL_B     6'h04
`define OFS_CONTROL_C     6'h08
`define OFS_TIMING        6'h0c
`define OFS_CHAN0_LOW     6'h10
`define OFS_CHAN0_HIGH    6'h14
`define OFS_CHAN1_LOW     6'h18
`define OFS_CHAN1_HIGH    6'h1c
`define OFS_GAIN          6'h20
`define OFS_OFFSET        6'h24
`define OFS_STATUS        6'h28

// control_a fields
`define BIT_MODULE_ENABLE 0
`define BIT_CHAN0_ENABLE  2
`define BIT_CHAN1_ENABLE  3
`define BIT_ADC_ROUTE     4

// control_b fields
`define BIT_CHAN0_TRIG    0
`define BIT_CHAN1_TRIG    1
`define MODE_LSB          5
`define MODE_MSB          6
`define MODE_SINGLE       2'h0
`define MODE_DUAL         2'h2

// control_c fields
`define BIT_LEFT_ADJUST   0
`define REF_LSB           3
`define REF_MSB           4
`define REF_BANDGAP       2'h0
`define REF_SUPPLY        2'h1
`define REF_EXTERNAL      2'h2

// timing_control fields
`define REFRESH_LSB       0
`define REFRESH_MSB       3
`define SEP_LSB           4
`define SEP_MSB           6

// Calibration fields
`define CAL_DIR_BIT       6
`define CAL_MAG_MSB       5
`define GAIN_SHIFT        11

// Reset values
`define RST_BYTE          8'h00
`define RST_CAL           7'h00
`define RST_CODE          12'h000

`endif

// file: dac_control.v
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dac_ctrl_map.vh"

module dac_control (
  input  wire        mclk,
  input  wire        nrst,
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  input  wire        eventChan0,
  input  wire        eventChan1,
  output reg  [11:0] convCode,
  output reg         convStart,
  output reg         sampleChan0,
  output reg         sampleChan1,
  output reg         holdBypass,
  output reg         outEnable0,
  output reg         outEnable1,
  output reg  [1:0]  refSelect,
  output reg         adcRoute
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg [7:0]  controlA;
  reg [7:0]  controlB;
  reg [7:0]  controlC;
  reg [7:0]  timingControl;
  reg [7:0]  chan0Low;
  reg [7:0]  chan0High;
  reg [7:0]  chan1Low;
  reg [7:0]  chan1High;
  reg [6:0]  gainCorrection;
  reg [6:0]  offsetCorrection;
  reg [1:0]  state;
  reg        pending0;
  reg        pending1;
  reg        refreshDue;
  reg        refreshing;
  reg        refreshCh1Left;
  reg [7:0]  sepCount;
  reg [16:0] refreshCount;

  wire       acc        = (read | write) & ~waitrequest;
  wire       wrAcc      = acc & write & byteenable[0];
  wire       enabled    = controlA[`BIT_MODULE_ENABLE];
  wire [1:0] mode       = controlB[`MODE_MSB:`MODE_LSB];
  wire       dualMode   = (mode == `MODE_DUAL);
  wire       evTrig0    = controlB[`BIT_CHAN0_TRIG];
  wire       evTrig1    = controlB[`BIT_CHAN1_TRIG];
  wire       leftAdjust = controlC[`BIT_LEFT_ADJUST];
  wire [3:0] refreshSel = timingControl[`REFRESH_MSB:`REFRESH_LSB];
  wire [2:0] sepSel     = timingControl[`SEP_MSB:`SEP_LSB];
  wire [11:0] value0;
  wire [11:0] value1;
  wire [16:0] refreshLen;
  wire [7:0]  sepLen;
  wire        refreshTick;
  wire        req0;
  wire        req1;

  // Byte pair to 12-bit code; reset state is right adjusted
  function [11:0] joinValue;
    input [7:0] lo;
    input [7:0] hi;
    input       left;
    begin
      if (left) begin
        joinValue = {hi, lo[7:4]};
      end else begin
        joinValue = {hi[3:0], lo};
      end
    end
  endfunction

  // Sign-magnitude correction, saturated to the code range
  function [11:0] calibrate;
    input [11:0] v;
    input [6:0]  gain;
    input [6:0]  offs;
    reg   [17:0] prod;
    reg   [13:0] sum;
    begin
      prod = v * gain[`CAL_MAG_MSB:0];
      sum  = {2'b00, v};
      if (gain[`CAL_DIR_BIT]) begin
        sum = sum - {7'h00, prod[17:`GAIN_SHIFT]};
      end else begin
        sum = sum + {7'h00, prod[17:`GAIN_SHIFT]};
      end
      if (offs[`CAL_DIR_BIT]) begin
        sum = sum - {8'h00, offs[`CAL_MAG_MSB:0]};
      end else begin
        sum = sum + {8'h00, offs[`CAL_MAG_MSB:0]};
      end
      if (sum[13]) begin
        calibrate = 12'h000;
      end else if (sum[12]) begin
        calibrate = 12'hfff;
      end else begin
        calibrate = sum[11:0];
      end
    end
  endfunction

  assign value0 = joinValue(chan0Low, chan0High, leftAdjust);
  assign value1 = joinValue(chan1Low, chan1High, leftAdjust);

  // Power-of-two intervals: sep 0x04 -> 16, refresh 0x06 -> 128
  assign sepLen     = 8'h01 << sepSel;
  assign refreshLen = 17'h00002 << refreshSel;

  // Refresh field zero turns the automatic refresh off
  assign refreshTick = enabled & dualMode & (refreshSel != 4'h0) &
                       (refreshCount == refreshLen - 17'h00001);

  // High byte write or event, chosen per channel
  assign req0 = enabled & (evTrig0 ? eventChan0
                : (wrAcc && address == `OFS_CHAN0_HIGH));
  assign req1 = enabled & dualMode & (evTrig1 ? eventChan1
                : (wrAcc && address == `OFS_CHAN1_HIGH));

  // Avalon slave: one wait cycle, then a single answer cycle
  always @(posedge mclk) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest) begin
        case (address)
          `OFS_CONTROL_A: readdata <= {24'h000000, controlA};
          `OFS_CONTROL_B: readdata <= {24'h000000, controlB};
          `OFS_CONTROL_C: readdata <= {24'h000000, controlC};
          `OFS_TIMING:    readdata <= {24'h000000, timingControl};
          `OFS_CHAN0_LOW: readdata <= {24'h000000, chan0Low};
          `OFS_CHAN0_HIGH: readdata <= {24'h000000, chan0High};
          `OFS_CHAN1_LOW: readdata <= {24'h000000, chan1Low};
          `OFS_CHAN1_HIGH: readdata <= {24'h000000, chan1High};
          `OFS_GAIN:      readdata <= {25'h0, gainCorrection};
          `OFS_OFFSET:    readdata <= {25'h0, offsetCorrection};
          `OFS_STATUS:    readdata <= {28'h0000000, refreshing, state[1], pending1, pending0};
          default:        readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Register writes; unmapped offsets are ignored
  always @(posedge mclk) begin
    if (!nrst) begin
      controlA         <= `RST_BYTE;
      controlB         <= `RST_BYTE;
      controlC         <= `RST_BYTE;
      timingControl    <= `RST_BYTE;
      chan0Low         <= `RST_BYTE;
      chan0High        <= `RST_BYTE;
      chan1Low         <= `RST_BYTE;
      chan1High        <= `RST_BYTE;
      gainCorrection   <= `RST_CAL;
      offsetCorrection <= `RST_CAL;
    end else if (wrAcc) begin
      case (address)
        `OFS_CONTROL_A:  controlA <= writedata[7:0];
        `OFS_CONTROL_B:  controlB <= writedata[7:0];
        `OFS_CONTROL_C:  controlC <= writedata[7:0];
        `OFS_TIMING:     timingControl <= writedata[7:0];
        `OFS_CHAN0_LOW:  chan0Low <= writedata[7:0];
        `OFS_CHAN0_HIGH: chan0High <= writedata[7:0];
        `OFS_CHAN1_LOW:  chan1Low <= writedata[7:0];
        `OFS_CHAN1_HIGH: chan1High <= writedata[7:0];
        `OFS_GAIN:       gainCorrection <= writedata[6:0];
        `OFS_OFFSET:     offsetCorrection <= writedata[6:0];
        default:         controlA <= controlA;
      endcase
    end
  end

  // Free-running refresh interval, untouched by extra conversions
  always @(posedge mclk) begin
    if (!nrst) begin
      refreshCount <= 17'h00000;
    end else if (!enabled || !dualMode || refreshSel == 4'h0 || refreshTick) begin
      refreshCount <= 17'h00000;
    end else begin
      refreshCount <= refreshCount + 17'h00001;
    end
  end

  // Shared conversion stage scheduler
  always @(posedge mclk) begin
    if (!nrst) begin
      state          <= ST_IDLE;
      pending0       <= 1'b0;
      pending1       <= 1'b0;
      refreshDue     <= 1'b0;
      refreshing     <= 1'b0;
      refreshCh1Left <= 1'b0;
      sepCount       <= 8'h00;
      convCode       <= `RST_CODE;
      convStart      <= 1'b0;
      sampleChan0    <= 1'b0;
      sampleChan1    <= 1'b0;
    end else if (!enabled) begin
      state          <= ST_IDLE;
      pending0       <= 1'b0;
      pending1       <= 1'b0;
      refreshDue     <= 1'b0;
      refreshing     <= 1'b0;
      refreshCh1Left <= 1'b0;
      convStart      <= 1'b0;
      sampleChan0    <= 1'b0;
      sampleChan1    <= 1'b0;
    end else begin
      convStart   <= 1'b0;
      sampleChan0 <= 1'b0;
      sampleChan1 <= 1'b0;
      if (refreshTick) begin
        refreshDue <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (refreshDue || refreshTick) begin
            // Refresh outranks waiting requests, which stay pending
            refreshDue     <= 1'b0;
            refreshing     <= 1'b1;
            refreshCh1Left <= 1'b1;
            convCode       <= calibrate(value0, gainCorrection, offsetCorrection);
            convStart      <= 1'b1;
            sampleChan0    <= 1'b1;
            sepCount       <= sepLen - 8'h01;
            state          <= ST_BUSY;
          end else if (pending0) begin
            convCode    <= calibrate(value0, gainCorrection, offsetCorrection);
            convStart   <= 1'b1;
            sampleChan0 <= dualMode;
            sepCount    <= sepLen - 8'h01;
            state       <= ST_BUSY;
          end else if (pending1 && dualMode) begin
            convCode    <= calibrate(value1, gainCorrection, offsetCorrection);
            convStart   <= 1'b1;
            sampleChan1 <= 1'b1;
            sepCount    <= sepLen - 8'h01;
            state       <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (sepCount != 8'h00) begin
            sepCount <= sepCount - 8'h01;
          end else if (refreshing && refreshCh1Left && dualMode) begin
            refreshCh1Left <= 1'b0;
            convCode       <= calibrate(value1, gainCorrection, offsetCorrection);
            convStart      <= 1'b1;
            sampleChan1    <= 1'b1;
            sepCount       <= sepLen - 8'h01;
          end else begin
            refreshing <= 1'b0;
            state      <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // Clear on service first, so a new request in that cycle survives
      if (state == ST_IDLE && !(refreshDue || refreshTick)) begin
        if (pending0) begin
          pending0 <= 1'b0;
        end else if (pending1 && dualMode) begin
          pending1 <= 1'b0;
        end
      end
      // A second request while one is pending merges into it
      if (req0) begin
        pending0 <= 1'b1;
      end
      if (req1) begin
        pending1 <= 1'b1;
      end
    end
  end

  // Static outputs; no interrupt line exists by design
  always @(posedge mclk) begin
    if (!nrst) begin
      holdBypass <= 1'b1;
      outEnable0 <= 1'b0;
      outEnable1 <= 1'b0;
      refSelect  <= `REF_BANDGAP;
      adcRoute   <= 1'b0;
    end else begin
      holdBypass <= ~dualMode;
      outEnable0 <= enabled & controlA[`BIT_CHAN0_ENABLE];
      outEnable1 <= enabled & dualMode & controlA[`BIT_CHAN1_ENABLE];
      refSelect  <= controlC[`REF_MSB:`REF_LSB];
      adcRoute   <= enabled & controlA[`BIT_ADC_ROUTE];
    end
  end

endmodule

// file: dac_control_asserts.sv
`timescale 1ns/1ps
`include "dac_ctrl_map.vh"
module dac_control_asserts (
  input wire        mclk,
  input wire        nrst,
  input wire [5:0]  address,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire        waitrequest,
  input wire        convStart,
  input wire        sampleChan0,
  input wire        sampleChan1,
  input wire        holdBypass,
  input wire        outEnable0,
  input wire        outEnable1,
  input wire [1:0]  refSelect,
  input wire        adcRoute
);
  reg  [7:0] ctlA, ctlB, ctlC, tim, gap;
  wire       wrOk = write && !waitrequest && byteenable[0];
  wire       dual = ctlB[`MODE_MSB:`MODE_LSB] == `MODE_DUAL;
  // Shadow copies of the control bytes, taken at the accepting edge
  always @(posedge mclk) begin
    if (!nrst) begin
      {ctlA, ctlB, ctlC, tim, gap} <= {32'h0, 8'hff};
    end else begin
      if (wrOk && address == `OFS_CONTROL_A) ctlA <= writedata[7:0];
      if (wrOk && address == `OFS_CONTROL_B) ctlB <= writedata[7:0];
      if (wrOk && address == `OFS_CONTROL_C) ctlC <= writedata[7:0];
      if (wrOk && address == `OFS_TIMING) tim <= writedata[7:0];
      gap <= convStart ? 8'h01 : gap + {7'h0, gap != 8'hff};
    end
  end
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Two steady edges, so registered outputs have caught up
  sequence s_steady;
    $stable(ctlA) && $stable(ctlB) && $stable(ctlC);
  endsequence
  sequence s_off;
    !ctlA[`BIT_MODULE_ENABLE] [*3];
  endsequence
  property p_bypass; s_steady |-> holdBypass == !dual; endproperty
  property p_ch1Dual; sampleChan1 |-> $past(dual); endproperty
  property p_alt; sampleChan1 |-> convStart && !sampleChan0; endproperty
  property p_enable;
    s_steady ##0 ctlA[0] |-> outEnable0 == ctlA[2] && outEnable1 == (ctlA[3] && dual);
  endproperty
  property p_off; s_off |-> !convStart && !outEnable0 && !outEnable1; endproperty
  property p_ref; s_steady |-> refSelect == ctlC[`REF_MSB:`REF_LSB]; endproperty
  property p_route; s_steady ##0 ctlA[0] |-> adcRoute == ctlA[4]; endproperty
  property p_sep; convStart && tim[`SEP_MSB:`SEP_LSB] == 3'h4 |-> gap >= 8'h10; endproperty
  a_bypass: assert property (p_bypass)
    else $error("hold bypass does not follow mode");
  a_ch1Dual: assert property (p_ch1Dual)
    else $error("channel 1 sampled outside dual mode");
  a_alt: assert property (p_alt)
    else $error("sample pulse without its own conversion");
  a_enable: assert property (p_enable)
    else $error("output enables do not follow their bits");
  a_off: assert property (p_off)
    else $error("activity while module disabled");
  a_ref: assert property (p_ref)
    else $error("reference select mismatch");
  a_route: assert property (p_route)
    else $error("adc route mismatch");
  a_sep: assert property (p_sep)
    else $error("conversions closer than separation");
endmodule
bind dac_control dac_control_asserts chk (.mclk(mclk), .nrst(nrst), .address(address),
  .write(write), .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .convStart(convStart), .sampleChan0(sampleChan0), .sampleChan1(sampleChan1),
  .holdBypass(holdBypass), .outEnable0(outEnable0), .outEnable1(outEnable1),
  .refSelect(refSelect), .adcRoute(adcRoute));

// file: dac_event_source.sv
`timescale 1ns/1ps
module dac_event_source (
  input  wire mclk,
  output reg  eventChan0,
  output reg  eventChan1
);
  initial begin
    eventChan0 = 1'b0;
    eventChan1 = 1'b0;
  end
  // Timed one-cycle event, used instead of write triggers where a channel's trigger bit is set
  task fire(input ch);
    @(posedge mclk);
    if (ch) eventChan1 <= 1'b1;
    else eventChan0 <= 1'b1;
    @(posedge mclk);
    eventChan0 <= 1'b0;
    eventChan1 <= 1'b0;
  endtask
endmodule

// file: dac_control_tb.sv
`timescale 1ns/1ps
`include "dac_ctrl_map.vh"
`define CHK(g, e) check(g, e)
module dac_control_tb;
  reg         mclk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
  reg  [5:0]  address = 6'h00;
  reg  [31:0] writedata = 32'h0;
  reg  [3:0]  byteenable = 4'h0;
  wire [31:0] readdata;
  wire [11:0] convCode;
  wire [1:0]  refSelect;
  wire        waitrequest, eventChan0, eventChan1, convStart, sampleChan0, sampleChan1;
  wire        holdBypass, outEnable0, outEnable1, adcRoute;
  integer     nErrors = 0, cmpCount = 0, cycles = 0;
  always #2 mclk = ~mclk;
  dac_control DUT (.mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .eventChan0(eventChan0), .eventChan1(eventChan1),
    .convCode(convCode), .convStart(convStart), .sampleChan0(sampleChan0),
    .sampleChan1(sampleChan1), .holdBypass(holdBypass), .outEnable0(outEnable0),
    .outEnable1(outEnable1), .refSelect(refSelect), .adcRoute(adcRoute));
  dac_event_source evSrc (.mclk(mclk), .eventChan0(eventChan0), .eventChan1(eventChan1));
  task check(input [31:0] got, input [31:0] exp);
    cmpCount = cmpCount + 1;
    if (got !== exp) begin
      nErrors = nErrors + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (nErrors == 0 && cmpCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hung design is cut off here
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      nErrors = nErrors + 1;
      tally_and_finish;
    end
  end
  task bus(input [5:0] a, input rd, input [31:0] d, output [31:0] q);
    @(posedge mclk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    byteenable <= 4'hf;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task wr(input [5:0] a, input [7:0] d);
    reg [31:0] q;
    bus(a, 1'b0, {24'h0, d}, q);
  endtask
  task rdChk(input [5:0] a, input [31:0] e);
    reg [31:0] q;
    bus(a, 1'b1, 32'h0, q);
    `CHK(q, e);
  endtask
  // Gives up after 300 edges, so n==300 means no conversion
  task waitStart(output [11:0] c, output [1:0] s, output integer n);
    n = 0;
    do begin
      @(posedge mclk);
      n = n + 1;
    end while (convStart !== 1'b1 && n < 300);
    c = convCode;
    s = {sampleChan1, sampleChan0};
  endtask
  task conv0(input [7:0] lo, input [7:0] hi, output [11:0] c, output [1:0] s);
    integer n;
    wr(`OFS_CHAN0_LOW, lo);
    wr(`OFS_CHAN0_HIGH, hi);
    waitStart(c, s, n);
  endtask
  // Sign of the direction bit is open, so both directions must mirror
  task calPair(input [5:0] a, input [7:0] m, input [11:0] diff);
    reg [11:0] p, q;
    reg [1:0]  s;
    wr(a, m);
    conv0(8'h00, 8'h08, p, s);
    wr(a, m | 8'h40);
    conv0(8'h00, 8'h08, q, s);
    wr(a, 8'h00);
    `CHK(p + q, 32'h1000);
    `CHK(p > q ? p - q : q - p, diff);
  endtask
  task t_regs;
    rdChk(`OFS_GAIN, 32'h0);
    wr(`OFS_GAIN, 8'hff);
    rdChk(`OFS_GAIN, 32'h7f);
    wr(`OFS_GAIN, 8'h00);
    rdChk(6'h2c, 32'h0);
  endtask
  task t_single;
    reg [11:0] c;
    reg [1:0]  s;
    wr(`OFS_CONTROL_C, 8'h08);
    wr(`OFS_CONTROL_B, 8'h00);
    wr(`OFS_CONTROL_A, 8'h15);
    conv0(8'h34, 8'h12, c, s);
    `CHK(c, 12'h234);
    `CHK(s, 2'b00);
    `CHK({holdBypass, outEnable0, outEnable1, refSelect, adcRoute}, 6'h33);
    wr(`OFS_CONTROL_C, 8'h09);
    conv0(8'h50, 8'hab, c, s);
    `CHK(c, 12'hab5);
    wr(`OFS_CONTROL_C, 8'h08);
    calPair(`OFS_OFFSET, 8'h05, 12'd10);
    calPair(`OFS_GAIN, 8'h10, 12'd32);
  endtask
  task t_event;
    reg [11:0] c;
    reg [1:0]  s;
    integer    n;
    wr(`OFS_CONTROL_B, 8'h01);
    wr(`OFS_CHAN0_LOW, 8'h78);
    wr(`OFS_CHAN0_HIGH, 8'h05);
    waitStart(c, s, n);
    `CHK(n, 300);
    evSrc.fire(1'b0);
    waitStart(c, s, n);
    `CHK(c, 12'h578);
    wr(`OFS_CONTROL_A, 8'h14);
    evSrc.fire(1'b0);
    waitStart(c, s, n);
    `CHK(n, 300);
    wr(`OFS_CONTROL_A, 8'h1d);
  endtask
  task t_dual;
    reg [11:0] c;
    reg [1:0]  s;
    integer    n;
    wr(`OFS_CONTROL_B, 8'h40);
    wr(`OFS_TIMING, 8'h40);
    calPair(`OFS_OFFSET, 8'h05, 12'd10);
    `CHK(holdBypass, 1'b0);
    wr(`OFS_CHAN1_LOW, 8'h21);
    wr(`OFS_CHAN1_HIGH, 8'h03);
    waitStart(c, s, n);
    `CHK({s, c}, 14'h2321);
    wr(`OFS_TIMING, 8'h46);
    do waitStart(c, s, n); while (s !== 2'b01);
    waitStart(c, s, n);
    `CHK(n, 32'h10);
    `CHK({s, c}, 14'h2321);
    waitStart(c, s, n);
    `CHK(n, 32'h70);
    `CHK({s, c}, 14'h1800);
    waitStart(c, s, n);
    `CHK(n, 32'h10);
    `CHK({s, c}, 14'h2321);
    // Refresh off first, so no refresh lands inside the no-trigger wait
    wr(`OFS_TIMING, 8'h40);
    wr(`OFS_CONTROL_B, 8'h42);
    wr(`OFS_CHAN1_LOW, 8'h54);
    wr(`OFS_CHAN1_HIGH, 8'h06);
    waitStart(c, s, n);
    `CHK(n, 32'h12c);
    evSrc.fire(1'b1);
    waitStart(c, s, n);
    `CHK({s, c}, 14'h2654);
    rdChk(`OFS_STATUS, 32'h4);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_regs;
    t_single;
    t_event;
    t_dual;
    tally_and_finish;
  end
endmodule
